// ===== core/dpvc_core.sv
// power sequencer, ratio selection and digital gain of the converter control core
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - auto ratio measurement tolerates 32 reference periods
// - supports ratios 128fs to 1152fs
// - two-bit power field, reset off
// - reference loss forces off, registers kept
// - sequencer steps through all intermediate stages, except on reference loss, which jumps straight to off
// - off stops clocks, disables all blocks
// - standby runs internal clock, charge pump and control only
// - entering muted powers blocks sequentially
// - entering play releases mute
// - play to muted applies soft mute
// - to standby powers blocks down sequentially
// - off disables charge pump too
// - per-channel gain -100dB to +12dB, 0.25dB
// - gain code mapping saturates at +12dB
// - update bit applies both channels together
// - gain only under serial bus control
// - ratio auto when slave and select zero, else field
module dpvc_core #(
   parameter int SOFTMUTE_CYC = dpvc_pkg::SOFTMUTE_CYCLES,
   parameter int STEP_CYC = dpvc_pkg::STEP_CYCLES,
   parameter int LOSS_CYC = dpvc_pkg::REF_LOSS_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire dpvc_pkg::dpvc_req_t req,
   output logic [15:0] rdata,
   output logic rvalid,
   input wire logic ref_tick,
   input wire logic frame_clk,
   input wire logic master_mode,
   input wire logic hw_mode,
   output dpvc_pkg::dpvc_pwr_t pwr,
   output logic [8:0] left_gain_out,
   output logic [8:0] right_gain_out,
   output logic [2:0] ratio_in_use,
   output logic ratio_ok,
   output logic [1:0] power_level,
   output logic ref_clk_ok
);

   typedef enum logic [3:0] {
      S_OFF, S_CP_UP, S_STBY, S_PATH_UP, S_MUTED, S_PLAY, S_SOFTMUTE, S_PATH_DOWN
   } dpvc_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [1:0] power_state_select_ff;
   logic [2:0] clock_ratio_select_ff;
   logic [8:0] left_gain_code_ff;
   logic [8:0] right_gain_code_ff;
   logic left_gain_apply_ff;
   logic right_gain_apply_ff;
   logic [8:0] left_applied_ff;
   logic [8:0] right_applied_ff;
   logic [15:0] rdata_ff;
   logic rvalid_ff;
   logic [15:0] nxt_rdata;
   logic [15:0] loss_cnt_ff;
   logic clk_ok_ff;
   dpvc_state_t state_ff;
   dpvc_state_t nxt_state;
   logic [19:0] wait_ff;
   logic [2:0] blocks_ff;
   logic [1:0] target;
   logic wait_done;
   logic [1:0] level;
   logic [2:0] det_code;
   logic det_valid;
   logic [2:0] nxt_ratio;
   logic [2:0] ratio_ff;
   logic ratio_ok_ff;
   logic apply_now;
   dpvc_pkg::dpvc_pwr_t pwr_ff;

   // clamp codes above the top step to +12dB
   function automatic logic [8:0] sat_gain(input logic [8:0] code);
      return (code >= dpvc_pkg::GAIN_MAX) ? dpvc_pkg::GAIN_MAX : code;
   endfunction

   // power level that a sequencer state presents
   function automatic logic [1:0] state_level(input dpvc_state_t s);
      logic [1:0] lv;
      case (s)
         S_OFF: lv = dpvc_pkg::PWR_OFF;
         S_MUTED, S_SOFTMUTE: lv = dpvc_pkg::PWR_MUTED;
         S_PLAY: lv = dpvc_pkg::PWR_PLAY;
         default: lv = dpvc_pkg::PWR_STBY;
      endcase
      return lv;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register file writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_state_select_ff <= dpvc_pkg::PWR_RST;
         clock_ratio_select_ff <= dpvc_pkg::RATIO_RST;
      end else if (req.wr) begin
         if (req.addr == dpvc_pkg::ADDR_PWR) begin
            power_state_select_ff <= req.wdata[dpvc_pkg::PWR_LSB +: 2];
         end
         if (req.addr == dpvc_pkg::ADDR_RATIO) begin
            clock_ratio_select_ff <= req.wdata[dpvc_pkg::RATIO_LSB +: 3];
         end
      end
   end

   // gain codes are stored on every write; the update bit is latched too
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_gain_code_ff <= dpvc_pkg::GAIN_RST;
         right_gain_code_ff <= dpvc_pkg::GAIN_RST;
         left_gain_apply_ff <= dpvc_pkg::APPLY_RST;
         right_gain_apply_ff <= dpvc_pkg::APPLY_RST;
      end else if (req.wr) begin
         if (req.addr == dpvc_pkg::ADDR_GAINL) begin
            left_gain_code_ff <= req.wdata[dpvc_pkg::GAIN_CODE_LSB +: 9];
            left_gain_apply_ff <= req.wdata[dpvc_pkg::GAIN_APPLY_BIT];
         end
         if (req.addr == dpvc_pkg::ADDR_GAINR) begin
            right_gain_code_ff <= req.wdata[dpvc_pkg::GAIN_CODE_LSB +: 9];
            right_gain_apply_ff <= req.wdata[dpvc_pkg::GAIN_APPLY_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronised gain update of both channels
   assign apply_now = req.wr && req.wdata[dpvc_pkg::GAIN_APPLY_BIT] &&
                      (req.addr == dpvc_pkg::ADDR_GAINL || req.addr == dpvc_pkg::ADDR_GAINR);

   // the incoming code is used for the written channel, the stored one for the other
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_applied_ff <= dpvc_pkg::GAIN_RST;
         right_applied_ff <= dpvc_pkg::GAIN_RST;
      end else if (apply_now && !hw_mode) begin
         if (req.addr == dpvc_pkg::ADDR_GAINL) begin
            left_applied_ff <= sat_gain(req.wdata[8:0]);
            right_applied_ff <= sat_gain(right_gain_code_ff);
         end else begin
            left_applied_ff <= sat_gain(left_gain_code_ff);
            right_applied_ff <= sat_gain(req.wdata[8:0]);
         end
      end
   end

   // pin control runs at unity gain; the range is -100dB..+12dB
   assign left_gain_out = hw_mode ? dpvc_pkg::GAIN_0DB : left_applied_ff;
   assign right_gain_out = hw_mode ? dpvc_pkg::GAIN_0DB : right_applied_ff;

   ////////////////////////////////////////////////////////////////////////////
   // reference clock watchdog: too long without a tick means the clock stopped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         loss_cnt_ff <= '0;
         clk_ok_ff <= 1'b0;
      end else if (ref_tick) begin
         loss_cnt_ff <= '0;
         clk_ok_ff <= 1'b1;
      end else if (int'(loss_cnt_ff) >= LOSS_CYC - 1) begin
         clk_ok_ff <= 1'b0;
      end else begin
         loss_cnt_ff <= loss_cnt_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame ratio measurement
   dpvc_ratio_detect u_detect (
      .clk(clk),
      .resetn(resetn),
      .ref_tick(ref_tick),
      .frame_clk(frame_clk),
      .clear(!clk_ok_ff),
      .ratio_code(det_code),
      .ratio_valid(det_valid)
   );

   // slave auto mode takes the measured ratio, else the written field
   always_comb begin
      if (!master_mode && clock_ratio_select_ff == dpvc_pkg::RATIO_AUTO) begin
         nxt_ratio = det_code;
      end else begin
         nxt_ratio = clock_ratio_select_ff;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ratio_ff <= 3'h0;
         ratio_ok_ff <= 1'b0;
      end else begin
         ratio_ff <= nxt_ratio;
         ratio_ok_ff <= (nxt_ratio != dpvc_pkg::RATIO_AUTO);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power sequencer
   // a stopped reference clock drags the target to off; registers stay
   assign target = clk_ok_ff ? power_state_select_ff : dpvc_pkg::PWR_OFF;
   assign wait_done = (wait_ff == '0);
   assign level = state_level(state_ff);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_OFF: begin
            if (target != dpvc_pkg::PWR_OFF) begin
               nxt_state = S_CP_UP;
            end
         end
         S_CP_UP: begin
            if (wait_done) begin
               nxt_state = S_STBY;
            end
         end
         S_STBY: begin
            if (target == dpvc_pkg::PWR_OFF) begin
               nxt_state = S_OFF;
            end else if (target != dpvc_pkg::PWR_STBY) begin
               nxt_state = S_PATH_UP;
            end
         end
         S_PATH_UP: begin
            if (target < dpvc_pkg::PWR_MUTED) begin
               nxt_state = S_PATH_DOWN;
            end else if (wait_done && int'(blocks_ff) == dpvc_pkg::PATH_BLOCKS) begin
               nxt_state = S_MUTED;
            end
         end
         S_MUTED: begin
            if (target == dpvc_pkg::PWR_PLAY) begin
               nxt_state = S_PLAY;
            end else if (target != dpvc_pkg::PWR_MUTED) begin
               nxt_state = S_PATH_DOWN;
            end
         end
         S_PLAY: begin
            if (target != dpvc_pkg::PWR_PLAY) begin
               nxt_state = S_SOFTMUTE;
            end
         end
         S_SOFTMUTE: begin
            if (target == dpvc_pkg::PWR_PLAY) begin
               nxt_state = S_PLAY;
            end else if (wait_done) begin
               nxt_state = S_MUTED;
            end
         end
         S_PATH_DOWN: begin
            if (target >= dpvc_pkg::PWR_MUTED) begin
               nxt_state = S_PATH_UP;
            end else if (wait_done && blocks_ff == 3'h0) begin
               nxt_state = S_STBY;
            end
         end
         default: nxt_state = S_OFF;
      endcase
      if (!clk_ok_ff) begin
         nxt_state = S_OFF;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= S_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // step timer: reloaded on every state change and after each block step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_ff <= '0;
      end else if (nxt_state != state_ff) begin
         wait_ff <= (nxt_state == S_SOFTMUTE) ? 20'(SOFTMUTE_CYC - 1) : 20'(STEP_CYC - 1);
      end else if (!wait_done) begin
         wait_ff <= wait_ff - 20'h00001;
      end else if (state_ff == S_PATH_UP || state_ff == S_PATH_DOWN) begin
         wait_ff <= 20'(STEP_CYC - 1);
      end
   end

   // one path block on or off per step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         blocks_ff <= 3'h0;
      end else if (nxt_state == S_OFF) begin
         blocks_ff <= 3'h0;
      end else if (state_ff == S_PATH_UP && wait_done &&
                   int'(blocks_ff) < dpvc_pkg::PATH_BLOCKS) begin
         blocks_ff <= blocks_ff + 3'h1;
      end else if (state_ff == S_PATH_DOWN && wait_done && blocks_ff != 3'h0) begin
         blocks_ff <= blocks_ff - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power control outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwr_ff <= '0;
         pwr_ff.mute <= 1'b1;
      end else begin
         pwr_ff.int_clk_en <= (nxt_state != S_OFF);
         pwr_ff.charge_pump_en <= (nxt_state != S_OFF);
         pwr_ff.control_en <= (nxt_state != S_OFF);
         for (int i = 0; i < dpvc_pkg::PATH_BLOCKS; i++) begin
            pwr_ff.path_en[i] <= (int'(blocks_ff) > i) && (nxt_state != S_OFF);
         end
         pwr_ff.config_done <= (nxt_state == S_MUTED || nxt_state == S_PLAY ||
                                nxt_state == S_SOFTMUTE);
         pwr_ff.mute <= (nxt_state != S_PLAY);
         pwr_ff.soft_mute <= (nxt_state == S_SOFTMUTE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads, answered one cycle after the strobe
   always_comb begin
      nxt_rdata = 16'h0000;
      case (req.addr)
         dpvc_pkg::ADDR_PWR: nxt_rdata[dpvc_pkg::PWR_LSB +: 2] = power_state_select_ff;
         dpvc_pkg::ADDR_RATIO: nxt_rdata[dpvc_pkg::RATIO_LSB +: 3] = clock_ratio_select_ff;
         dpvc_pkg::ADDR_GAINL: nxt_rdata[9:0] = {left_gain_apply_ff, left_gain_code_ff};
         dpvc_pkg::ADDR_GAINR: nxt_rdata[9:0] = {right_gain_apply_ff, right_gain_code_ff};
         dpvc_pkg::ADDR_STATUS: begin
            nxt_rdata[dpvc_pkg::STAT_LEVEL_LSB +: 2] = level;
            nxt_rdata[dpvc_pkg::STAT_RATIO_LSB +: 3] = ratio_ff;
            nxt_rdata[dpvc_pkg::STAT_VALID_BIT] = det_valid;
            nxt_rdata[dpvc_pkg::STAT_BUSY_BIT] = (level != target);
            nxt_rdata[dpvc_pkg::STAT_CLKOK_BIT] = clk_ok_ff;
         end
         default: nxt_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= req.rd;
         if (req.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign rdata = rdata_ff;
   assign rvalid = rvalid_ff;
   assign pwr = pwr_ff;
   assign ratio_in_use = ratio_ff;
   assign ratio_ok = ratio_ok_ff;
   assign power_level = level;
   assign ref_clk_ok = clk_ok_ff;

endmodule
`default_nettype wire

// ===== core/dpvc_pkg.sv
// constants, field layouts and carrier types of the converter control core
package dpvc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets on the serial control port
   localparam logic [6:0] ADDR_PWR = 7'h02;
   localparam logic [6:0] ADDR_RATIO = 7'h04;
   localparam logic [6:0] ADDR_GAINL = 7'h06;
   localparam logic [6:0] ADDR_GAINR = 7'h07;
   localparam logic [6:0] ADDR_STATUS = 7'h0A;

   // field positions
   localparam int PWR_LSB = 0;
   localparam int RATIO_LSB = 0;
   localparam int GAIN_CODE_LSB = 0;
   localparam int GAIN_APPLY_BIT = 9;
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_RATIO_LSB = 2;
   localparam int STAT_VALID_BIT = 5;
   localparam int STAT_BUSY_BIT = 6;
   localparam int STAT_CLKOK_BIT = 7;

   // reset values
   localparam logic [1:0] PWR_RST = 2'h0;
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [8:0] GAIN_RST = 9'h188;
   localparam logic APPLY_RST = 1'b0;

   // power state field codes
   localparam logic [1:0] PWR_OFF = 2'h0;
   localparam logic [1:0] PWR_STBY = 2'h1;
   localparam logic [1:0] PWR_MUTED = 2'h2;
   localparam logic [1:0] PWR_PLAY = 2'h3;

   // gain code landmarks: zero code is -100dB, 0.25dB per code
   localparam logic [8:0] GAIN_0DB = 9'h190;
   localparam logic [8:0] GAIN_MAX = 9'h1C0;

   // ratio select codes and reference periods per frame
   localparam logic [2:0] RATIO_AUTO = 3'h0;
   localparam int RATIO_TOL = 32;
   localparam int RATIO_CNT_W = 12;
   localparam logic [11:0] RATIO_TABLE [1:7] = '{12'h080, 12'h0C0, 12'h100, 12'h180,
                                                 12'h200, 12'h300, 12'h480};

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int STEP_TIME_NS = 2000;
   localparam int SOFTMUTE_TIME_NS = 100000;
   localparam int REF_LOSS_NS = 10000;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFTMUTE_CYCLES = (SOFTMUTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_LOSS_CYCLES = REF_LOSS_NS / CLK_PERIOD_NS;
   localparam int PATH_BLOCKS = 4;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } dpvc_req_t;

   typedef struct packed {
      logic int_clk_en;
      logic charge_pump_en;
      logic control_en;
      logic [PATH_BLOCKS-1:0] path_en;
      logic config_done;
      logic mute;
      logic soft_mute;
   } dpvc_pwr_t;

endpackage

// ===== core/dpvc_ratio_detect.sv
// reference-to-frame clock ratio detector
`timescale 1ns/1ps
`default_nettype none
module dpvc_ratio_detect #(
   parameter int CNT_W = dpvc_pkg::RATIO_CNT_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ref_tick,
   input wire logic frame_clk,
   input wire logic clear,
   output logic [2:0] ratio_code,
   output logic ratio_valid
);

   logic frame_d_ff;
   logic [CNT_W-1:0] count_ff;
   logic [2:0] code_ff;
   logic valid_ff;
   logic frame_rise;

   // match a period count against the ratio table within the tolerance
   function automatic logic [2:0] classify(input logic [CNT_W-1:0] cnt);
      logic [2:0] res;
      int diff;
      res = 3'h0;
      for (int i = 1; i <= 7; i++) begin
         diff = int'(cnt) - int'(dpvc_pkg::RATIO_TABLE[i]);
         if (diff <= dpvc_pkg::RATIO_TOL && diff >= -dpvc_pkg::RATIO_TOL) begin
            res = 3'(i);
         end
      end
      return res;
   endfunction

   assign frame_rise = frame_clk & ~frame_d_ff;

   // frame edge history
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frame_d_ff <= 1'b0;
      end else begin
         frame_d_ff <= frame_clk;
      end
   end

   // reference periods per frame, saturating
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= '0;
      end else if (clear || frame_rise) begin
         count_ff <= '0;
      end else if (ref_tick && count_ff != '1) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   // classify each completed frame; tolerance of 32 periods
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         code_ff <= 3'h0;
         valid_ff <= 1'b0;
      end else if (clear) begin
         code_ff <= 3'h0;
         valid_ff <= 1'b0;
      end else if (frame_rise) begin
         code_ff <= classify(count_ff);
         valid_ff <= (classify(count_ff) != 3'h0);
      end
   end

   assign ratio_code = code_ff;
   assign ratio_valid = valid_ff;

endmodule
`default_nettype wire

// ===== verification/dpvc_clk_source.sv
// audio source model giving reference ticks and a locked frame clock
`timescale 1ns/1ps
`default_nettype none
module dpvc_clk_source (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [11:0] ratio,
   output logic ref_tick,
   output logic frame_clk
);
   logic [11:0] cnt_ff;
   ////////////////////////////////////////////////////////////////////////////
   // one tick per cycle, frame every ratio ticks; both stand still when stopped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 12'h000;
         ref_tick <= 1'b0;
         frame_clk <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 12'h000;
         ref_tick <= 1'b0;
         frame_clk <= 1'b0;
      end else begin
         cnt_ff <= (cnt_ff >= ratio - 12'h001) ? 12'h000 : cnt_ff + 12'h001;
         ref_tick <= 1'b1;
         frame_clk <= (cnt_ff < (ratio >> 1));
      end
   end
endmodule
`default_nettype wire

// ===== verification/dpvc_core_properties.sv
// port checks of the converter control core
`timescale 1ns/1ps
`default_nettype none
module dpvc_core_properties #(
   parameter int SOFTMUTE_CYC = dpvc_pkg::SOFTMUTE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire dpvc_pkg::dpvc_req_t req,
   input wire logic hw_mode,
   input wire dpvc_pkg::dpvc_pwr_t pwr,
   input wire logic [8:0] left_gain_out,
   input wire logic [8:0] right_gain_out,
   input wire logic [1:0] power_level,
   input wire logic ref_clk_ok
);
   logic [15:0] sm_cnt_ff;
   logic [8:0] sat_code;
   logic gain_apply;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   // saturated code on the write bus, and an apply write that pin control does not block
   assign sat_code = (req.wdata[8:0] >= dpvc_pkg::GAIN_MAX) ? dpvc_pkg::GAIN_MAX : req.wdata[8:0];
   assign gain_apply = req.wr && req.wdata[9] && !hw_mode;
   // length of the current soft-mute run
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sm_cnt_ff <= 16'h0000;
      end else begin
         sm_cnt_ff <= pwr.soft_mute ? sm_cnt_ff + 16'h0001 : 16'h0000;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_off_all_dark: assert property (
      power_level == 2'h0 |-> !pwr.int_clk_en && !pwr.charge_pump_en && pwr.path_en == '0)
      else $error("blocks enabled in off state");
   chk_path_needs_pump: assert property (
      pwr.path_en != '0 |-> pwr.charge_pump_en && pwr.control_en)
      else $error("signal path up without pump");
   chk_play_unmuted: assert property (
      power_level == 2'h3 |-> !pwr.mute && pwr.path_en == '1 && pwr.config_done)
      else $error("play state not fully up");
   chk_low_muted: assert property (
      power_level <= 2'h1 |-> pwr.mute)
      else $error("output unmuted below muted state");
   chk_one_block_step: assert property (
      ref_clk_ok && $past(ref_clk_ok) |-> $countones(pwr.path_en ^ $past(pwr.path_en)) <= 1)
      else $error("several path blocks switched at once");
   chk_softmute_bound: assert property (
      pwr.soft_mute |-> sm_cnt_ff <= SOFTMUTE_CYC - 1)
      else $error("soft mute overran");
   chk_loss_to_off: assert property (
      $fell(ref_clk_ok) |-> ##[0:1] power_level == 2'h0)
      else $error("no fall to off on clock loss");
   chk_apply_left: assert property (
      gain_apply && req.addr == dpvc_pkg::ADDR_GAINL |=> left_gain_out == $past(sat_code))
      else $error("left gain not applied");
   chk_apply_right: assert property (
      gain_apply && req.addr == dpvc_pkg::ADDR_GAINR |=> right_gain_out == $past(sat_code))
      else $error("right gain not applied");
   chk_store_only: assert property (
      req.wr && !req.wdata[9] && !hw_mode |=> $stable(left_gain_out) && $stable(right_gain_out))
      else $error("gain moved without update bit");
   chk_hw_fixed_gain: assert property (
      hw_mode && $past(hw_mode) |-> left_gain_out == dpvc_pkg::GAIN_0DB
      && right_gain_out == dpvc_pkg::GAIN_0DB)
      else $error("gain not fixed under pin control");
   // main scenarios reached
   cov_play: cover property (power_level == 2'h3);
   cov_softmute: cover property ($rose(pwr.soft_mute));
   cov_loss: cover property ($fell(ref_clk_ok));
endmodule
bind dpvc_core dpvc_core_properties #(.SOFTMUTE_CYC(SOFTMUTE_CYC)) chk_u (.clk(clk),
   .resetn(resetn), .req(req), .hw_mode(hw_mode), .pwr(pwr), .left_gain_out(left_gain_out),
   .right_gain_out(right_gain_out), .power_level(power_level), .ref_clk_ok(ref_clk_ok));
`default_nettype wire

// ===== verification/dpvc_core_tb.sv
// self-checking bench of the converter control core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module dpvc_core_tb;
   logic clk, resetn, hw_mode, master_mode, run, rvalid, ratio_ok;
   logic ref_clk_ok, ref_tick, frame_clk, seen_play;
   dpvc_pkg::dpvc_req_t req;
   dpvc_pkg::dpvc_pwr_t pwr;
   logic [15:0] rdata;
   logic [8:0] gl, gr;
   logic [2:0] ratio_in_use;
   logic [1:0] power_level;
   logic [11:0] ratio;
   int err_total = 0;
   int n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////
   // design with shortened step, soft-mute and loss counts, and the clock source
   dpvc_core #(.SOFTMUTE_CYC(4), .STEP_CYC(2), .LOSS_CYC(8)) dut_u (.clk(clk),
      .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid), .ref_tick(ref_tick),
      .frame_clk(frame_clk), .master_mode(master_mode), .hw_mode(hw_mode), .pwr(pwr),
      .left_gain_out(gl), .right_gain_out(gr), .ratio_in_use(ratio_in_use),
      .ratio_ok(ratio_ok), .power_level(power_level), .ref_clk_ok(ref_clk_ok));
   dpvc_clk_source src_u (.clk(clk), .resetn(resetn), .run(run), .ratio(ratio),
      .ref_tick(ref_tick), .frame_clk(frame_clk));
   // clock and play-state monitor
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (power_level === 2'h3) seen_play <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic settle();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", e, rdata)
   endtask
   task automatic wait_lvl(input logic [1:0] l, input logic [3:0] pe);
      int i;
      for (i = 0; i < 300 && !(power_level === l && pwr.path_en === pe); i++) settle();
      `CHK("power_level", l, power_level)
      `CHK("path_en", pe, pwr.path_en)
      if (i == 300) begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic wait_ratio(input logic [2:0] c);
      int i;
      for (i = 0; i < 5000 && ratio_in_use !== c; i++) settle();
      `CHK("ratio_in_use", c, ratio_in_use)
      if (i == 5000) begin
         err_total++;
         report_and_stop();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      req = '0;
      hw_mode = 1'b0;
      master_mode = 1'b0;
      run = 1'b0;
      seen_play = 1'b0;
      ratio = 12'h100;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      `CHK("pwr", 10'h002, pwr)
      rd(dpvc_pkg::ADDR_PWR, 16'h0000);
      rd(dpvc_pkg::ADDR_GAINL, 16'h0188);
      rd(dpvc_pkg::ADDR_GAINR, 16'h0188);
      rd(7'h01, 16'h0000);
      run <= 1'b1;
      wr(dpvc_pkg::ADDR_PWR, 16'h0003);
      wr(dpvc_pkg::ADDR_PWR, 16'h0001);
      wait_lvl(2'h1, 4'h0);
      repeat (30) settle();
      `CHK("seen_play", 1'b0, seen_play)
      `CHK("charge_pump_en", 1'b1, pwr.charge_pump_en)
      wr(dpvc_pkg::ADDR_PWR, 16'h0003);
      wait_lvl(2'h3, 4'hF);
      `CHK("mute", 1'b0, pwr.mute)
      `CHK("config_done", 1'b1, pwr.config_done)
      wr(dpvc_pkg::ADDR_PWR, 16'h0002);
      wait_lvl(2'h2, 4'hF);
      `CHK("mute", 1'b1, pwr.mute)
      `CHK("soft_mute", 1'b1, pwr.soft_mute)
      wr(dpvc_pkg::ADDR_PWR, 16'h0001);
      wait_lvl(2'h1, 4'h0);
      `CHK("charge_pump_en", 1'b1, pwr.charge_pump_en)
      wr(dpvc_pkg::ADDR_PWR, 16'h0000);
      wait_lvl(2'h0, 4'h0);
      `CHK("pwr", 10'h002, pwr)
      wr(dpvc_pkg::ADDR_PWR, 16'h0001);
      wait_lvl(2'h1, 4'h0);
      @(posedge clk) run <= 1'b0;
      wait_lvl(2'h0, 4'h0);
      rd(dpvc_pkg::ADDR_PWR, 16'h0001);
      @(posedge clk) run <= 1'b1;
      wait_lvl(2'h1, 4'h0);
      for (int i = 1; i <= 7; i++) begin
         @(posedge clk);
         ratio <= (i % 2) ? dpvc_pkg::RATIO_TABLE[i] + 12'h01F
                          : dpvc_pkg::RATIO_TABLE[i] - 12'h01F;
         wait_ratio(3'(i));
      end
      wr(dpvc_pkg::ADDR_RATIO, 16'h0005);
      wait_ratio(3'h5);
      `CHK("ratio_ok", 1'b1, ratio_ok)
      rd(dpvc_pkg::ADDR_STATUS, 16'h00B5);
      wr(dpvc_pkg::ADDR_RATIO, 16'h0000);
      @(posedge clk) master_mode <= 1'b1;
      wait_ratio(3'h0);
      `CHK("ratio_ok", 1'b0, ratio_ok)
      wr(dpvc_pkg::ADDR_GAINL, 16'h0100);
      settle();
      `CHK("left_gain", 9'h188, gl)
      rd(dpvc_pkg::ADDR_GAINL, 16'h0100);
      wr(dpvc_pkg::ADDR_GAINR, 16'h03FF);
      settle();
      `CHK("left_gain", 9'h100, gl)
      `CHK("right_gain", 9'h1C0, gr)
      wr(dpvc_pkg::ADDR_GAINR, 16'h0200);
      wr(dpvc_pkg::ADDR_GAINL, 16'h03BE);
      settle();
      `CHK("right_gain", 9'h000, gr)
      `CHK("left_gain", 9'h1BE, gl)
      @(posedge clk) hw_mode <= 1'b1;
      wr(dpvc_pkg::ADDR_GAINL, 16'h0250);
      settle();
      `CHK("left_gain", 9'h190, gl)
      `CHK("right_gain", 9'h190, gr)
      @(posedge clk) hw_mode <= 1'b0;
      settle();
      `CHK("left_gain", 9'h1BE, gl)
      report_and_stop();
   end
endmodule
`default_nettype wire
